//--- rtl/brfs_pkg.sv
package brfs_pkg;
    // register map, byte addresses on the avalon bus
    localparam logic [3:0] ADDR_STATUS = 4'h0; // fault status, read only
    localparam logic [3:0] ADDR_ENABLE = 4'h4; // comparator enable
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8; // sticky event bits, write one to clear
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc; // interrupt mask
    localparam int NUM_CH = 6;
    localparam logic [5:0] RESET_VAL = 6'h00;
    localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;
    // settling time and its cycle count at 200 MHz, least time rounded up
    localparam real SETTLE_MS = 2.5;
    localparam real CLK_MHZ = 200.0;
    localparam int SETTLE_CYC_CALC = int'($ceil(SETTLE_MS * 1000.0 * CLK_MHZ));
    localparam int CNT_W = 20;

    // analog comparator results entering the block, one bit per channel
    typedef struct packed {
        logic [5:0] ratioHigh; // ratio above threshold
        logic [5:0] lowVolt; // cell voltage too low
    } brfs_analog_t;

    // avalon-mm slave request
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } brfs_avreq_t;
endpackage : brfs_pkg

//--- rtl/brfs_settle.sv
`timescale 1ns/1ps
// per-channel settling timer: result valid once enabled long enough
module brfs_settle #(
    parameter int SETTLE_CYC = brfs_pkg::SETTLE_CYC_CALC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic enable,
    output logic settled
);
    logic [brfs_pkg::CNT_W-1:0] count_r;
    logic [brfs_pkg::CNT_W-1:0] count_nxt;
    // local copy of the counter width so the size cast stays a plain name
    localparam int CW = brfs_pkg::CNT_W;
    localparam logic [brfs_pkg::CNT_W-1:0] LAST = CW'(SETTLE_CYC - 1);

    // count while enabled; disable restarts the wait
    always_comb begin
        count_nxt = count_r;
        if (!enable) begin
            count_nxt = '0;
        end else if (count_r != LAST) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign settled = enable && (count_r == LAST);
endmodule : brfs_settle

//--- rtl/brfs_status.sv
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
// How it works
// (RULE1) ratio above threshold sets channel bit
// (RULE2) bit reads zero if below or disabled
// (RULE3) bit updates after 2.5 ms settling
// (RULE4) bit valid only while enable set
// (RULE5) read-only, resets zero, bits 7:6 zero
// (RULE6) low-voltage flag marks result untrustworthy
module brfs_status #(
    parameter int SETTLE_CYC = brfs_pkg::SETTLE_CYC_CALC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire brfs_pkg::brfs_analog_t analogIn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    logic [5:0] ratioSync1_r;
    logic [5:0] ratioSync2_r;
    logic [5:0] lowSync1_r;
    logic [5:0] lowSync2_r;
    logic [5:0] status_r;
    logic [5:0] status_nxt;
    logic [5:0] enable_r;
    logic [5:0] enable_nxt;
    logic [5:0] irqStat_r;
    logic [5:0] irqStat_nxt;
    logic [5:0] irqMask_r;
    logic [5:0] irqMask_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [5:0] settled;
    logic [5:0] trusted;
    logic wrStrobe;

    // zero-extend a six-bit register onto the 32-bit read bus
    function automatic logic [31:0] zext6(input logic [5:0] v);
        return {26'h0, v};
    endfunction : zext6

    // two-flop synchronisers for the analog comparator outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ratioSync1_r <= 6'h00;
            ratioSync2_r <= 6'h00;
            lowSync1_r <= 6'h00;
            lowSync2_r <= 6'h00;
        end else begin
            ratioSync1_r <= analogIn.ratioHigh;
            ratioSync2_r <= ratioSync1_r;
            lowSync1_r <= analogIn.lowVolt;
            lowSync2_r <= lowSync1_r;
        end
    end

    // one settling timer per channel
    for (genvar ch = 0; ch < brfs_pkg::NUM_CH; ch++) begin : g_settle
        // (RULE3) settling delay timer
        brfs_settle #(
            .SETTLE_CYC(SETTLE_CYC)
        ) u_settle (
            .mclk(mclk),
            .reset_n(reset_n),
            .enable(enable_r[ch]),
            .settled(settled[ch])
        );
    end

    // (RULE6) low voltage voids result
    assign trusted = settled & ~lowSync2_r;

    // status update: bits hold stale until settled, forced low when disabled
    always_comb begin
        status_nxt = status_r;
        for (int i = 0; i < brfs_pkg::NUM_CH; i++) begin
            // (RULE2) disabled reads zero
            // (RULE4) valid only when enabled
            if (!enable_r[i]) begin
                status_nxt[i] = 1'b0;
            // (RULE1) ratio compare result
            // (RULE3) update once settled
            end else if (trusted[i]) begin
                status_nxt[i] = ratioSync2_r[i];
            end
        end
    end

    // avalon slave: one wait cycle, then ack with registered read data
    assign wrStrobe = avs_write && !ack_r;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    always_comb begin
        ack_nxt = (avs_read || avs_write) && !ack_r;
        rdata_nxt = rdata_r;
        enable_nxt = enable_r;
        irqMask_nxt = irqMask_r;
        // new fault events set sticky bits; set wins over a clear
        irqStat_nxt = irqStat_r;
        if (wrStrobe && avs_address == brfs_pkg::ADDR_IRQ_STAT) begin
            irqStat_nxt = irqStat_r & ~avs_writedata[5:0];
        end
        irqStat_nxt = irqStat_nxt | (status_nxt & ~status_r);
        if (wrStrobe) begin
            case (avs_address)
                brfs_pkg::ADDR_ENABLE: enable_nxt = avs_writedata[5:0];
                brfs_pkg::ADDR_IRQ_MASK: irqMask_nxt = avs_writedata[5:0];
                // (RULE5) status ignores writes
                default: ;
            endcase
        end
        if (avs_read && !ack_r) begin
            case (avs_address)
                // (RULE5) reserved bits zero
                brfs_pkg::ADDR_STATUS: rdata_nxt = zext6(status_r);
                brfs_pkg::ADDR_ENABLE: rdata_nxt = zext6(enable_r);
                brfs_pkg::ADDR_IRQ_STAT: rdata_nxt = zext6(irqStat_r);
                brfs_pkg::ADDR_IRQ_MASK: rdata_nxt = zext6(irqMask_r);
                default: rdata_nxt = brfs_pkg::UNMAPPED_VAL;
            endcase
        end
    end

    // (RULE5) reset to zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= brfs_pkg::RESET_VAL;
            enable_r <= 6'h00;
            irqStat_r <= 6'h00;
            irqMask_r <= 6'h00;
            rdata_r <= 32'h00000000;
            ack_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
            irqStat_r <= irqStat_nxt;
            irqMask_r <= irqMask_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign irq = |(irqStat_r & irqMask_r); // level, held until cleared or masked

    // checks
    property p_disabled_zero;
        @(posedge mclk) disable iff (!reset_n)
        !enable_r[0] |=> !status_r[0];
    endproperty
    disabled_zero_a: assert property (p_disabled_zero) // RULE2
        else $error("status bit set while channel disabled");

    property p_set_when_high;
        @(posedge mclk) disable iff (!reset_n)
        (enable_r[0] && trusted[0] && ratioSync2_r[0]) |=> status_r[0];
    endproperty
    fault_set_a: assert property (p_set_when_high) // RULE1
        else $error("fault not reported");

    property p_enable_gate;
        @(posedge mclk) disable iff (!reset_n)
        status_r[1] |-> $past(enable_r[1]);
    endproperty
    enable_gate_a: assert property (p_enable_gate) // RULE4
        else $error("bit valid without enable");

    property p_unsettled_hold;
        @(posedge mclk) disable iff (!reset_n)
        (enable_r[0] && !settled[0]) |=> status_r[0] == $past(status_r[0]);
    endproperty
    settle_hold_a: assert property (p_unsettled_hold) // RULE3
        else $error("status changed before settling");

    property p_lowvolt_hold;
        @(posedge mclk) disable iff (!reset_n)
        (enable_r[2] && lowSync2_r[2]) |=> status_r[2] == $past(status_r[2]);
    endproperty
    low_volt_a: assert property (p_lowvolt_hold) // RULE6
        else $error("untrusted result taken");

    property p_reserved_zero;
        @(posedge mclk) disable iff (!reset_n)
        ack_r && $past(avs_address) == brfs_pkg::ADDR_STATUS |-> avs_readdata[31:6] == 26'h0;
    endproperty
    reserved_zero_a: assert property (p_reserved_zero) // RULE5
        else $error("reserved status bits nonzero");

    // (RULE5) only the comparator path or a disable moves a bit
    property p_status_ro;
        @(posedge mclk) disable iff (!reset_n)
        $changed(status_r[3]) |-> !$past(enable_r[3]) || $past(trusted[3]);
    endproperty
    status_ro_a: assert property (p_status_ro) // RULE5
        else $error("status bit written");

    property p_ratio_low;
        @(posedge mclk) disable iff (!reset_n)
        (enable_r[4] && trusted[4] && !ratioSync2_r[4]) |=> !status_r[4];
    endproperty
    ratio_low_a: assert property (p_ratio_low) // RULE2
        else $error("bit set with ratio below threshold");

    // (RULE1) rising fault latches event
    property p_sticky_set;
        @(posedge mclk) disable iff (!reset_n)
        $rose(status_r[0]) |-> irqStat_r[0];
    endproperty
    sticky_set_a: assert property (p_sticky_set) // RULE1
        else $error("fault event not latched");

    // (RULE5) register access answered promptly
    sequence s_req_open;
        (avs_read || avs_write) && !ack_r;
    endsequence
    property p_bus_answer;
        @(posedge mclk) disable iff (!reset_n)
        s_req_open |=> !avs_waitrequest;
    endproperty
    bus_answer_a: assert property (p_bus_answer) // RULE5
        else $error("register access not answered");
endmodule : brfs_status

//--- verification/brfs_status_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module brfs_status_tb;
    localparam int SETTLE = 8;
    localparam logic [3:0] ST = brfs_pkg::ADDR_STATUS;
    localparam logic [3:0] EN = brfs_pkg::ADDR_ENABLE;
    localparam logic [3:0] IS = brfs_pkg::ADDR_IRQ_STAT;
    localparam logic [3:0] IM = brfs_pkg::ADDR_IRQ_MASK;
    logic mclk, reset_n, avsRead, avsWrite, avsWaitrequest, irq;
    brfs_pkg::brfs_analog_t analogIn;
    logic [3:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata, rd;
    logic [5:0] en, lv, r, m, c, prev, cur, istat;
    int failures, compares;

    // short settling count keeps the run brief
    brfs_status #(.SETTLE_CYC(SETTLE)) u_brfs_status (
        .mclk(mclk),
        .reset_n(reset_n),
        .analogIn(analogIn),
        .avs_address(avsAddress),
        .avs_read(avsRead),
        .avs_write(avsWrite),
        .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest),
        .irq(irq)
    );

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // counts and verdict, the single end of the run
    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // one bus transfer; request held until waitrequest is sampled low
    // no cycle count is assumed here, the watchdog bounds a hung wait
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avsAddress <= a;
        avsRead <= ~wr;
        avsWrite <= wr;
        avsWritedata <= d;
        do begin
            @(posedge mclk);
        end while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : xfer

    // read a register and compare, upper bits must be zero
    task automatic rdChk(input logic [3:0] a, input logic [5:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, {26'h0, e})
    endtask : rdChk

    // low-voltage channels keep the old bit, disabled ones read zero
    function automatic logic [5:0] expStat(input logic [5:0] ra, ena, lo, held);
        return ((ra & ~lo) | (held & lo)) & ena;
    endfunction : expStat

    initial begin
        reset_n = 1'b0;
        analogIn = '0;
        avsAddress = 4'h0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0;
        failures = 0;
        compares = 0;
        void'($urandom(55));
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        rdChk(ST, 6'h00);
        rdChk(EN, 6'h00);
        rdChk(IS, 6'h00);
        rdChk(IM, 6'h00);
        rdChk(4'h6, 6'h00);
        `CHK(irq, 1'b0)
        $display("test reset done");
        analogIn.ratioHigh <= 6'h3f;
        xfer(1'b1, ST, 32'hffffffff);
        rdChk(ST, 6'h00);
        $display("test disabled done");
        xfer(1'b1, EN, 32'h3f);
        rdChk(ST, 6'h00);
        repeat (SETTLE + 4) @(posedge mclk);
        rdChk(ST, 6'h3f);
        cur = 6'h3f;
        istat = 6'h3f;
        $display("test settle done");
        // random enables, ratios, flags and irq traffic
        for (int i = 0; i < 24; i++) begin
            en = 6'($urandom);
            r = 6'($urandom);
            lv = (i % 6 == 0) ? 6'h3f : 6'($urandom & $urandom);
            m = 6'($urandom);
            c = 6'($urandom);
            prev = cur;
            xfer(1'b1, EN, {26'h0, en});
            analogIn <= {r, lv};
            repeat (SETTLE + 4) @(posedge mclk);
            cur = expStat(r, en, lv, prev);
            istat = istat | (cur & ~prev);
            rdChk(ST, cur);
            xfer(1'b1, IM, {26'h0, m});
            xfer(1'b1, IS, {26'h0, c});
            istat = istat & ~c;
            rdChk(IS, istat);
            rdChk(IM, m);
            `CHK(irq, |(istat & m))
        end
        $display("test random done");
        close_out();
    end

    // watchdog, far beyond the expected run of under 1000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        $display("Error at %0t: watchdog expired", $time);
        failures++;
        close_out();
    end
endmodule : brfs_status_tb
